// ### rtl/ssr_pkg.sv
// Purpose: Constants for the instrument status register bank
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes: Register select codes are local choices
// Functional notes
// - Normal-activity register is sixteen bits wide
// - Bit 0 set while calibrating
// - Bit 5 set while awaiting trigger
// - Bit 5 summarises detailed trigger status; code has no trigger register, copies awaiting_start_event
// - Event read returns value, then clears
// - Condition read returns live bits, no change
// - Normal-activity mask writable, readable; host limits range
// - Normal rise filter read/write, defaults 32767
// - Normal fall filter read/write, defaults zero
// - Fault register is sixteen bits wide
// - Fault bits 0,1,3,4: voltage, current, power, heat
// - Fault bits 9,10,11: low voltage, alarm, reverse
// - Fault mask writable, readable; host limits range
// - Fault rise filter defaults 32767, readable
// - Fault fall filter defaults zero, readable
// - Summary bits 0-3: CC, CV, CR, CP regulation
// - Summary bit 8 set while sequence runs
// - Queries answered as unsigned decimal text
// - Status bit 7: masked normal-activity event pending
// - Status bit 3: masked fault event pending
// - Status bit 2: any summary bit set
// - Preset clears masks, restores filters, keeps events
package ssr_pkg;
	localparam int REG_W = 16;
	localparam logic [15:0] NA_USED = 16'h0021;
	localparam logic [15:0] FLT_USED = 16'h0E1B;
	localparam logic [15:0] SUM_USED = 16'h010F;
	localparam logic [15:0] RISE_RST = 16'h7FFF;
	localparam logic [15:0] FALL_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam int NA_CAL_BIT = 0;
	localparam int NA_AWAITING_START_EVENT_BIT = 5;
	localparam int FLT_OV_BIT = 0;
	localparam int FLT_OC_BIT = 1;
	localparam int FLT_OP_BIT = 3;
	localparam int FLT_OT_BIT = 4;
	localparam int FLT_UV_BIT = 9;
	localparam int FLT_EXT_BIT = 10;
	localparam int FLT_REV_BIT = 11;
	localparam int STB_SUM_BIT = 2;
	localparam int STB_FLT_BIT = 3;
	localparam int STB_NA_BIT = 7;
	localparam int DIGITS = 5;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	typedef enum logic [3:0] {
		SEL_NA_EVENT, SEL_NA_LIVE_STATE_QUERY, SEL_NA_MASK, SEL_NA_RISE, SEL_NA_FALL,
		SEL_FLT_EVENT, SEL_FLT_LIVE_STATE_QUERY, SEL_FLT_MASK, SEL_FLT_RISE, SEL_FLT_FALL,
		SEL_SUM_LIVE_STATE_QUERY
	} ssr_sel_t;
endpackage

// ### rtl/ssr_decimal.sv
`timescale 1ns/1ns
// Purpose: Serialise a 16-bit value as unsigned decimal characters
// Assumes: Consumer takes a character when char_valid and char_ready
// Notes: Leading zeros suppressed; zero sends one character
module ssr_decimal
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Value in
	input wire logic start,
	input wire logic [15:0] value,
	output logic busy,
	// Character out
	output logic [7:0] char_data,
	output logic char_valid,
	output logic char_last,
	input wire logic char_ready
);
	typedef enum logic [1:0] {D_IDLE, D_CONV, D_SEND} ssr_dstate_t;
	ssr_dstate_t state_reg, state_next;
	logic [15:0] rem_reg, rem_next;
	logic [2:0] idx_reg, idx_next;
	logic [3:0] dig_reg [DIGITS];
	logic [3:0] dig_next [DIGITS];
	logic started_reg, started_next;

	function automatic logic [15:0] pow10(input logic [2:0] i);
		unique case (i)
			3'd0: pow10 = 16'd10000;
			3'd1: pow10 = 16'd1000;
			3'd2: pow10 = 16'd100;
			3'd3: pow10 = 16'd10;
			default: pow10 = 16'd1;
		endcase
	endfunction

	always_comb begin
		state_next = state_reg;
		rem_next = rem_reg;
		idx_next = idx_reg;
		dig_next = dig_reg;
		started_next = started_reg;
		unique case (state_reg)
			D_IDLE: begin
				if (start) begin
					rem_next = value;
					idx_next = 3'd0;
					dig_next[0] = 4'd0;
					state_next = D_CONV;
				end
			end
			D_CONV: begin
				if (rem_reg >= pow10(idx_reg)) begin
					rem_next = rem_reg - pow10(idx_reg);
					dig_next[idx_reg] = dig_reg[idx_reg] + 4'd1;
				end else if (idx_reg == 3'(DIGITS - 1)) begin
					idx_next = 3'd0;
					started_next = 1'b0;
					state_next = D_SEND;
				end else begin
					idx_next = idx_reg + 3'd1;
					dig_next[idx_reg + 3'd1] = 4'd0;
				end
			end
			D_SEND: begin
				if (!started_reg && dig_reg[idx_reg] == 4'd0 && idx_reg != 3'(DIGITS - 1)) begin
					idx_next = idx_reg + 3'd1;
				end else if (char_ready) begin
					started_next = 1'b1;
					if (idx_reg == 3'(DIGITS - 1)) begin
						state_next = D_IDLE;
					end else begin
						idx_next = idx_reg + 3'd1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= D_IDLE;
			rem_reg <= 16'h0000;
			idx_reg <= 3'd0;
			started_reg <= 1'b0;
			for (int i = 0; i < DIGITS; i++) begin
				dig_reg[i] <= 4'd0;
			end
		end else begin
			state_reg <= state_next;
			rem_reg <= rem_next;
			idx_reg <= idx_next;
			started_reg <= started_next;
			dig_reg <= dig_next;
		end
	end

	assign busy = (state_reg != D_IDLE);
	assign char_valid = (state_reg == D_SEND) &&
		(started_reg || dig_reg[idx_reg] != 4'd0 || idx_reg == 3'(DIGITS - 1));
	assign char_data = ASCII_ZERO + {4'h0, dig_reg[idx_reg]};
	assign char_last = (idx_reg == 3'(DIGITS - 1));
endmodule

// ### rtl/ssr_status_bank.sv
`timescale 1ns/1ns
// Purpose: Status register bank for normal-activity, fault and summary groups
// Assumes: Condition inputs are asynchronous levels; host port is synchronous
// Notes: Query answers come out as decimal characters
module ssr_status_bank
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Instrument conditions
	input wire logic calibrating,
	input wire logic awaiting_start_event,
	input wire logic surplus_voltage_flag,
	input wire logic surplus_current_flag,
	input wire logic surplus_power_flag,
	input wire logic heat_fault_flag,
	input wire logic low_voltage_flag,
	input wire logic outside_alarm_flag,
	input wire logic polarity_inverted_flag,
	input wire logic constant_current_regulating,
	input wire logic constant_voltage_regulating,
	input wire logic constant_resistance_regulating,
	input wire logic constant_power_regulating,
	input wire logic sequence_running,
	// Host command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic cmd_preset,
	input wire logic [3:0] cmd_sel,
	input wire logic [15:0] cmd_wdata,
	// Query answer
	output logic [7:0] resp_char,
	output logic resp_valid,
	output logic resp_last,
	input wire logic resp_ready,
	// Summary bits
	output logic [7:0] status_byte
);
	logic [13:0] sync1_reg, sync2_reg;
	logic calibrating_s, awaiting_start_event_s;
	logic surplus_voltage_flag_s, surplus_current_flag_s, surplus_power_flag_s;
	logic heat_fault_flag_s, low_voltage_flag_s, outside_alarm_flag_s;
	logic polarity_inverted_flag_s;
	logic constant_current_regulating_s, constant_voltage_regulating_s;
	logic constant_resistance_regulating_s, constant_power_regulating_s;
	logic sequence_running_s;
	logic [15:0] na_live_state_query_reg, na_live_state_query_next;
	logic [15:0] flt_live_state_query_reg, flt_live_state_query_next;
	logic [15:0] sum_live_state_query_reg, sum_live_state_query_next;
	logic [15:0] na_evt_reg, na_evt_next;
	logic [15:0] flt_evt_reg, flt_evt_next;
	logic [15:0] na_mask_reg, na_mask_next;
	logic [15:0] flt_mask_reg, flt_mask_next;
	logic [15:0] na_rise_reg, na_rise_next;
	logic [15:0] na_fall_reg, na_fall_next;
	logic [15:0] flt_rise_reg, flt_rise_next;
	logic [15:0] flt_fall_reg, flt_fall_next;
	logic [7:0] stb_reg, stb_next;
	logic [15:0] rd_val;
	logic conv_busy, take, rd_take;
	logic wr_take, preset_take, na_evt_rd, flt_evt_rd;
	logic wr_na_mask, wr_na_rise, wr_na_fall;
	logic wr_flt_mask, wr_flt_rise, wr_flt_fall;

	function automatic logic [15:0] edge_hits(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [15:0] rise, input logic [15:0] fall, input logic [15:0] used);
		edge_hits = ((~old_v & new_v & rise) | (old_v & ~new_v & fall)) & used;
	endfunction

	function automatic logic sel_is(input logic [3:0] sel, input ssr_sel_t code);
		sel_is = (sel == code);
	endfunction

	// Two-stage synchronisers on condition inputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1_reg <= 14'h0000;
			sync2_reg <= 14'h0000;
		end else begin
			sync1_reg <= {calibrating, awaiting_start_event, surplus_voltage_flag,
				surplus_current_flag, surplus_power_flag, heat_fault_flag,
				low_voltage_flag, outside_alarm_flag, polarity_inverted_flag,
				constant_current_regulating, constant_voltage_regulating,
				constant_resistance_regulating, constant_power_regulating,
				sequence_running};
			sync2_reg <= sync1_reg;
		end
	end

	// Synchronised condition levels
	assign calibrating_s = sync2_reg[13];
	assign awaiting_start_event_s = sync2_reg[12];
	assign surplus_voltage_flag_s = sync2_reg[11];
	assign surplus_current_flag_s = sync2_reg[10];
	assign surplus_power_flag_s = sync2_reg[9];
	assign heat_fault_flag_s = sync2_reg[8];
	assign low_voltage_flag_s = sync2_reg[7];
	assign outside_alarm_flag_s = sync2_reg[6];
	assign polarity_inverted_flag_s = sync2_reg[5];
	assign constant_current_regulating_s = sync2_reg[4];
	assign constant_voltage_regulating_s = sync2_reg[3];
	assign constant_resistance_regulating_s = sync2_reg[2];
	assign constant_power_regulating_s = sync2_reg[1];
	assign sequence_running_s = sync2_reg[0];

	// Host command decode
	assign cmd_ready = !conv_busy;
	assign take = cmd_valid && cmd_ready;
	assign rd_take = take && !cmd_write && !cmd_preset;
	assign wr_take = take && cmd_write && !cmd_preset;
	assign preset_take = take && cmd_preset;
	assign na_evt_rd = rd_take && sel_is(cmd_sel, SEL_NA_EVENT);
	assign flt_evt_rd = rd_take && sel_is(cmd_sel, SEL_FLT_EVENT);
	assign wr_na_mask = wr_take && sel_is(cmd_sel, SEL_NA_MASK);
	assign wr_na_rise = wr_take && sel_is(cmd_sel, SEL_NA_RISE);
	assign wr_na_fall = wr_take && sel_is(cmd_sel, SEL_NA_FALL);
	assign wr_flt_mask = wr_take && sel_is(cmd_sel, SEL_FLT_MASK);
	assign wr_flt_rise = wr_take && sel_is(cmd_sel, SEL_FLT_RISE);
	assign wr_flt_fall = wr_take && sel_is(cmd_sel, SEL_FLT_FALL);

	// Normal-activity condition
	always_comb begin
		na_live_state_query_next = 16'h0000;
		na_live_state_query_next[NA_CAL_BIT] = calibrating_s;
		na_live_state_query_next[NA_AWAITING_START_EVENT_BIT] = awaiting_start_event_s;
	end

	// Fault condition
	always_comb begin
		flt_live_state_query_next = 16'h0000;
		flt_live_state_query_next[FLT_OV_BIT] = surplus_voltage_flag_s;
		flt_live_state_query_next[FLT_OC_BIT] = surplus_current_flag_s;
		flt_live_state_query_next[FLT_OP_BIT] = surplus_power_flag_s;
		flt_live_state_query_next[FLT_OT_BIT] = heat_fault_flag_s;
		flt_live_state_query_next[FLT_UV_BIT] = low_voltage_flag_s;
		flt_live_state_query_next[FLT_EXT_BIT] = outside_alarm_flag_s;
		flt_live_state_query_next[FLT_REV_BIT] = polarity_inverted_flag_s;
	end

	// Regulation summary condition
	always_comb begin
		sum_live_state_query_next = {7'h00, sequence_running_s, 4'h0, constant_power_regulating_s,
			constant_resistance_regulating_s, constant_voltage_regulating_s,
			constant_current_regulating_s};
	end

	// Event group
	always_comb begin
		na_evt_next = na_evt_reg;
		flt_evt_next = flt_evt_reg;
		if (na_evt_rd) begin
			na_evt_next = 16'h0000;
		end
		if (flt_evt_rd) begin
			flt_evt_next = 16'h0000;
		end
		na_evt_next = na_evt_next |
			edge_hits(na_live_state_query_reg, na_live_state_query_next, na_rise_reg, na_fall_reg, NA_USED);
		flt_evt_next = flt_evt_next |
			edge_hits(flt_live_state_query_reg, flt_live_state_query_next, flt_rise_reg, flt_fall_reg, FLT_USED);
	end

	// Mask and filter group
	always_comb begin
		na_mask_next = na_mask_reg;
		flt_mask_next = flt_mask_reg;
		na_rise_next = na_rise_reg;
		na_fall_next = na_fall_reg;
		flt_rise_next = flt_rise_reg;
		flt_fall_next = flt_fall_reg;
		if (preset_take) begin
			na_mask_next = MASK_RST;
			flt_mask_next = MASK_RST;
			na_rise_next = RISE_RST;
			na_fall_next = FALL_RST;
			flt_rise_next = RISE_RST;
			flt_fall_next = FALL_RST;
		end else begin
			if (wr_na_mask) begin
				na_mask_next = cmd_wdata;
			end
			if (wr_na_rise) begin
				na_rise_next = cmd_wdata;
			end
			if (wr_na_fall) begin
				na_fall_next = cmd_wdata;
			end
			if (wr_flt_mask) begin
				flt_mask_next = cmd_wdata;
			end
			if (wr_flt_rise) begin
				flt_rise_next = cmd_wdata;
			end
			if (wr_flt_fall) begin
				flt_fall_next = cmd_wdata;
			end
		end
	end

	// Status byte group
	always_comb begin
		stb_next = 8'h00;
		stb_next[STB_NA_BIT] = |(na_evt_next & na_mask_next);
		stb_next[STB_FLT_BIT] = |(flt_evt_next & flt_mask_next);
		stb_next[STB_SUM_BIT] = |(sum_live_state_query_next & SUM_USED);
	end

	always_comb begin
		unique case (cmd_sel)
			SEL_NA_EVENT: rd_val = na_evt_reg;
			SEL_NA_LIVE_STATE_QUERY: rd_val = na_live_state_query_reg;
			SEL_NA_MASK: rd_val = na_mask_reg;
			SEL_NA_RISE: rd_val = na_rise_reg;
			SEL_NA_FALL: rd_val = na_fall_reg;
			SEL_FLT_EVENT: rd_val = flt_evt_reg;
			SEL_FLT_LIVE_STATE_QUERY: rd_val = flt_live_state_query_reg;
			SEL_FLT_MASK: rd_val = flt_mask_reg;
			SEL_FLT_RISE: rd_val = flt_rise_reg;
			SEL_FLT_FALL: rd_val = flt_fall_reg;
			SEL_SUM_LIVE_STATE_QUERY: rd_val = sum_live_state_query_reg;
			default: rd_val = 16'h0000;
		endcase
	end

	// Condition group registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			na_live_state_query_reg <= 16'h0000;
			flt_live_state_query_reg <= 16'h0000;
			sum_live_state_query_reg <= 16'h0000;
		end else begin
			na_live_state_query_reg <= na_live_state_query_next;
			flt_live_state_query_reg <= flt_live_state_query_next;
			sum_live_state_query_reg <= sum_live_state_query_next;
		end
	end

	// Event group registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			na_evt_reg <= 16'h0000;
			flt_evt_reg <= 16'h0000;
		end else begin
			na_evt_reg <= na_evt_next;
			flt_evt_reg <= flt_evt_next;
		end
	end

	// Mask and filter group registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			na_mask_reg <= MASK_RST;
			flt_mask_reg <= MASK_RST;
			na_rise_reg <= RISE_RST;
			na_fall_reg <= FALL_RST;
			flt_rise_reg <= RISE_RST;
			flt_fall_reg <= FALL_RST;
		end else begin
			na_mask_reg <= na_mask_next;
			flt_mask_reg <= flt_mask_next;
			na_rise_reg <= na_rise_next;
			na_fall_reg <= na_fall_next;
			flt_rise_reg <= flt_rise_next;
			flt_fall_reg <= flt_fall_next;
		end
	end

	// Status byte register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stb_reg <= 8'h00;
		end else begin
			stb_reg <= stb_next;
		end
	end

	assign status_byte = stb_reg;

	ssr_decimal u_decimal (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(rd_take),
		.value(rd_val),
		.busy(conv_busy),
		.char_data(resp_char),
		.char_valid(resp_valid),
		.char_last(resp_last),
		.char_ready(resp_ready)
	);
endmodule

// ### tb/ssr_status_bank_asserts.sv
`timescale 1ns/1ns
// Purpose: Port assertions for the status bank
// Assumes: Idle while rst is high
// Notes: Summary checks allow for input sync delay
module ssr_status_bank_asserts
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Summary conditions
	input wire logic constant_current_regulating,
	input wire logic constant_voltage_regulating,
	input wire logic constant_resistance_regulating,
	input wire logic constant_power_regulating,
	input wire logic sequence_running,
	// Host port
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_write,
	input wire logic cmd_preset,
	// Answer and status
	input wire logic [7:0] resp_char,
	input wire logic resp_valid,
	input wire logic resp_last,
	input wire logic resp_ready,
	input wire logic [7:0] status_byte
);
	wire logic sum_any = constant_current_regulating | constant_voltage_regulating
		| constant_resistance_regulating | constant_power_regulating | sequence_running;
	wire logic take = cmd_valid & cmd_ready;
	wire logic rd_take = take & ~cmd_write & ~cmd_preset;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_stb_unused: assert property ((status_byte & 8'h73) == 8'h00)
		else $error("status byte unused bit set");
	chk_sum_high: assert property (sum_any [*6] |=> status_byte[2])
		else $error("summary bit missing");
	chk_sum_low: assert property (!sum_any [*6] |=> !status_byte[2])
		else $error("summary bit stuck");
	chk_preset_clear: assert property (take && cmd_preset |=> !status_byte[7] && !status_byte[3])
		else $error("masked bits after preset");
	chk_read_busy: assert property (rd_take |=> !cmd_ready)
		else $error("ready during answer");
	chk_read_answer: assert property (rd_take |-> ##[1:50] resp_valid)
		else $error("no answer to read");
	chk_resp_hold: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_char) && $stable(resp_last))
		else $error("answer char not held");
	chk_resp_digit: assert property (resp_valid |-> resp_char inside {[8'h30:8'h39]} && !cmd_ready)
		else $error("answer char not a digit");
	chk_ready_return: assert property (resp_valid && resp_ready && resp_last |=> ##[0:2] cmd_ready)
		else $error("ready not back after answer");
endmodule

// ### tb/ssr_status_bank_tb.sv
`timescale 1ns/1ns
// Purpose: Self-checking bench for the status bank
// Assumes: Inputs change on the falling edge
// Notes: Rows cover each condition input
module ssr_status_bank_tb import ssr_pkg::*;;
	logic ref_clk = 1'b0, rst = 1'b1, slow = 1'b0, resp_ready = 1'b1;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_preset = 1'b0;
	logic [13:0] cin = 14'h0000;
	logic [3:0] cmd_sel = 4'h0;
	logic [15:0] cmd_wdata = 16'h0000, v;
	logic cmd_ready, resp_valid, resp_last;
	logic [7:0] resp_char, status_byte;
	int err_total = 0, samples_checked = 0;
	int pos [14] = '{0, 5, 0, 1, 3, 4, 9, 10, 11, 0, 1, 2, 3, 8};
	int grp [14] = '{0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2};
	ssr_status_bank ssr_status_bank_inst (.ref_clk(ref_clk), .rst(rst),
		.calibrating(cin[0]), .awaiting_start_event(cin[1]),
		.surplus_voltage_flag(cin[2]), .surplus_current_flag(cin[3]),
		.surplus_power_flag(cin[4]), .heat_fault_flag(cin[5]), .low_voltage_flag(cin[6]),
		.outside_alarm_flag(cin[7]), .polarity_inverted_flag(cin[8]),
		.constant_current_regulating(cin[9]), .constant_voltage_regulating(cin[10]),
		.constant_resistance_regulating(cin[11]), .constant_power_regulating(cin[12]),
		.sequence_running(cin[13]), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_write(cmd_write), .cmd_preset(cmd_preset), .cmd_sel(cmd_sel),
		.cmd_wdata(cmd_wdata), .resp_char(resp_char), .resp_valid(resp_valid),
		.resp_last(resp_last), .resp_ready(resp_ready), .status_byte(status_byte));
	initial forever #25 ref_clk = ~ref_clk;
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] s, input logic [15:0] d, input logic p);
		@(negedge ref_clk);
		{cmd_valid, cmd_write, cmd_preset, cmd_sel, cmd_wdata} = {1'b1, ~p, p, s, d};
		do @(posedge ref_clk); while (cmd_ready !== 1'b1);
		@(negedge ref_clk);
		{cmd_valid, cmd_write, cmd_preset} = 3'h0;
	endtask
	task automatic rd(input logic [3:0] s, input logic [15:0] e);
		logic done;
		@(negedge ref_clk);
		{cmd_valid, cmd_sel} = {1'b1, s};
		do @(posedge ref_clk); while (cmd_ready !== 1'b1);
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		v = 16'h0000;
		done = 1'b0;
		while (!done) begin
			resp_ready = slow ? ~resp_ready : 1'b1;
			@(posedge ref_clk);
			if (resp_valid === 1'b1 && resp_ready) begin
				v = v * 16'h000a + {8'h00, resp_char} - 16'h0030;
				done = resp_last;
			end
			@(negedge ref_clk);
		end
		cmp(v, e);
	endtask
	task automatic conclude;
		$display("checked=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		conclude();
	end
	initial begin
		wt(10);
		rst = 1'b0;
		for (int i = 0; i < 14; i++) begin
			cin = 14'h0001 << i;
			wt(6);
			rd(4'(grp[i] == 2 ? 10 : 1 + 5 * grp[i]), 16'h0001 << pos[i]);
			if (grp[i] < 2) begin
				rd(4'(5 * grp[i]), 16'h0001 << pos[i]);
				rd(4'(5 * grp[i]), 16'h0000);
			end
			cin = 14'h0000;
			wt(6);
			if (grp[i] < 2)
				rd(4'(5 * grp[i]), 16'h0000);
		end
		slow = 1'b1;
		wr(4'h2, 16'h7fff, 1'b0);
		wr(4'h7, 16'h0001, 1'b0);
		wr(4'h4, 16'h0001, 1'b0);
		wr(4'h3, 16'h0000, 1'b0);
		rd(4'h2, 16'h7fff);
		rd(4'h7, 16'h0001);
		rd(4'h4, 16'h0001);
		rd(4'h3, 16'h0000);
		cin = 14'h0001;
		wt(6);
		rd(4'h0, 16'h0000);
		cin = 14'h0000;
		wt(6);
		cmp({8'h00, status_byte}, 16'h0080);
		cin = 14'h0204;
		wt(6);
		cmp({8'h00, status_byte}, 16'h008c);
		wr(4'h0, 16'h0000, 1'b1);
		cmp({8'h00, status_byte}, 16'h0004);
		rd(4'h2, 16'h0000);
		rd(4'h7, 16'h0000);
		rd(4'h3, 16'h7fff);
		rd(4'h4, 16'h0000);
		rd(4'h5, 16'h0001);
		rd(4'h0, 16'h0001);
		wr(4'h6, 16'hffff, 1'b0);
		rd(4'h6, 16'h0001);
		rd(4'hc, 16'h0000);
		cin = 14'h3fff;
		wt(6);
		rd(4'h1, 16'h0021);
		rd(4'h6, 16'h0e1b);
		rd(4'ha, 16'h010f);
		rd(4'h5, 16'h0e1a);
		rd(4'h0, 16'h0021);
		wr(4'h8, 16'h0001, 1'b0);
		wr(4'h9, 16'h0002, 1'b0);
		rd(4'h8, 16'h0001);
		rd(4'h9, 16'h0002);
		wr(4'h7, 16'h1234, 1'b0);
		rst = 1'b1;
		wt(10);
		rst = 1'b0;
		rd(4'h7, 16'h0000);
		rd(4'h8, 16'h7fff);
		rd(4'h9, 16'h0000);
		conclude();
	end
endmodule
bind ssr_status_bank ssr_status_bank_asserts ssr_status_bank_asserts_inst (.ref_clk, .rst,
	.constant_current_regulating, .constant_voltage_regulating,
	.constant_resistance_regulating, .constant_power_regulating, .sequence_running,
	.cmd_valid, .cmd_ready, .cmd_write, .cmd_preset, .resp_char, .resp_valid,
	.resp_last, .resp_ready, .status_byte);
